// *** src/receive_reassembly_engine_event_defs.svh ***
`ifndef RECEIVE_REASSEMBLY_ENGINE_EVENT_DEFS_SVH
`define RECEIVE_REASSEMBLY_ENGINE_EVENT_DEFS_SVH
// Summary of operation
// - misc error selected or test force loads misc source with structure address bits 15:0.
// - unselected misc error types leave the misc source register untouched.
// - misc counter increments on every cycle that a selected status error flag 9:5 is set.
// - test force bit also increments the misc counter without any real error.
// - write underrun or test force loads underrun source with structure address.
// - underrun counter increments once per write underrun and on test force.
// - write overrun or test force loads overrun source with structure address.
// - overrun counter increments once per write overrun and on test force.
// - counter rollover sets status flag 12, 13 or 14; writing one clears it.
// - test force bit 15 forces every event, driving counters and source loads.

// register offsets on the host port
`define MISC_SRC_OFS   16'h3010
`define MISC_CNT_OFS   16'h3012
`define UNDER_SRC_OFS  16'h3020
`define UNDER_CNT_OFS  16'h3022
`define OVER_SRC_OFS   16'h3030
`define OVER_CNT_OFS   16'h3032
`define STATUS_OFS     16'h3002

// field layout
`define EVT_WIDTH      16
`define MISC_SEL_W     5
`define ROLL_LSB       12
`define EVT_RESET      16'h0000
`define ROLL_RESET     3'h0

`endif

// *** src/receive_reassembly_engine_event_pkg.sv ***
`include "receive_reassembly_engine_event_defs.svh"
package receive_reassembly_engine_event_pkg;

   // event classes, index into the slot arrays
   typedef enum logic [1:0] {
      CLASS_MISC  = 2'b00,
      CLASS_UNDER = 2'b01,
      CLASS_OVER  = 2'b10
   } event_class_t;

   // logger-level state
   typedef struct packed {
      logic [`EVT_WIDTH-1:0] rdata;
      logic [2:0]            roll;
   } logger_state_t;

endpackage : receive_reassembly_engine_event_pkg

// *** src/event_slot.sv ***
`timescale 1ns/10ps
`include "receive_reassembly_engine_event_defs.svh"
module event_slot
   import receive_reassembly_engine_event_pkg::*;
#(
   parameter int W = `EVT_WIDTH
) (
   // clock and reset
   input  wire logic         core_clk,
   input  wire logic         sys_rst,
   // event side
   input  wire logic         hit,
   input  wire logic [W-1:0] src_in,
   // software writes
   input  wire logic         src_wr,
   input  wire logic         cnt_wr,
   input  wire logic [W-1:0] wdata,
   // stored values and wrap strobe
   output logic      [W-1:0] src,
   output logic      [W-1:0] cnt,
   output logic              wrap
);

   typedef struct packed {
      logic [W-1:0] src;
      logic [W-1:0] cnt;
   } slot_state_t;

   slot_state_t q;
   slot_state_t d;

   always_comb begin
      d = q;
      if (src_wr) begin
         d.src = wdata;
      end else if (hit) begin
         d.src = src_in;
      end
      if (cnt_wr) begin
         d.cnt = wdata;
      end else if (hit) begin
         d.cnt = q.cnt + 1'b1;
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // counter overflows on this increment
   assign wrap = hit & ~cnt_wr & (&q.cnt);
   assign src  = q.src;
   assign cnt  = q.cnt;

endmodule : event_slot

// *** src/receive_reassembly_engine_event_logger.sv ***
`timescale 1ns/10ps
`include "receive_reassembly_engine_event_defs.svh"
module receive_reassembly_engine_event_logger
   import receive_reassembly_engine_event_pkg::*;
#(
   parameter int W     = `EVT_WIDTH,
   parameter int SEL_W = `MISC_SEL_W
) (
   // clock and reset
   input  wire logic             core_clk,
   input  wire logic             sys_rst,
   // host register port
   input  wire logic [15:0]      reg_addr,
   input  wire logic             reg_wr,
   input  wire logic             reg_rd,
   input  wire logic [15:0]      reg_wdata,
   output logic      [15:0]      reg_rdata,
   // receive control bits
   input  wire logic [SEL_W-1:0] misc_select,
   input  wire logic             test_force_bit,
   // error events from the reassembly engine
   input  wire logic [SEL_W-1:0] misc_error_set,
   input  wire logic [W-1:0]     misc_struct_addr,
   input  wire logic             underrun_event,
   input  wire logic [W-1:0]     underrun_struct_addr,
   input  wire logic             overrun_event,
   input  wire logic [W-1:0]     overrun_struct_addr,
   // rollover status flags
   output logic                  misc_rollover_flag,
   output logic                  underrun_rollover_flag,
   output logic                  overrun_rollover_flag
);

   ////////////////////////////////////////////////////////////////////////////////
   // address decode

   function automatic logic sel(input logic [15:0] a, input logic [15:0] ofs);
      return a == ofs;
   endfunction : sel

   localparam logic [15:0] SRC_OFS [3] = '{`MISC_SRC_OFS, `UNDER_SRC_OFS, `OVER_SRC_OFS};
   localparam logic [15:0] CNT_OFS [3] = '{`MISC_CNT_OFS, `UNDER_CNT_OFS, `OVER_CNT_OFS};

   logic [2:0]   hit;
   logic [2:0]   src_wr;
   logic [2:0]   cnt_wr;
   logic [2:0]   wrap;
   logic [W-1:0] src_in [3];
   logic [W-1:0] src    [3];
   logic [W-1:0] cnt    [3];
   logic         stat_wr;
   logic         misc_real;

   logger_state_t q;
   logger_state_t d;

   ////////////////////////////////////////////////////////////////////////////////
   // event qualification

   // only selected misc types count
   assign misc_real = |(misc_error_set & misc_select);

   // test force makes every class fire
   assign hit[CLASS_MISC]  = misc_real | test_force_bit;
   assign hit[CLASS_UNDER] = underrun_event | test_force_bit;
   assign hit[CLASS_OVER]  = overrun_event | test_force_bit;

   assign src_in[CLASS_MISC]  = misc_struct_addr;
   assign src_in[CLASS_UNDER] = underrun_struct_addr;
   assign src_in[CLASS_OVER]  = overrun_struct_addr;

   assign stat_wr = reg_wr & sel(reg_addr, `STATUS_OFS);

   ////////////////////////////////////////////////////////////////////////////////
   // one source and counter pair per class

   for (genvar i = 0; i < 3; i++) begin : g_slot
      assign src_wr[i] = reg_wr & sel(reg_addr, SRC_OFS[i]);
      assign cnt_wr[i] = reg_wr & sel(reg_addr, CNT_OFS[i]);

      event_slot #(
         .W (W)
      ) u_slot (
         .core_clk (core_clk),
         .sys_rst  (sys_rst),
         .hit      (hit[i]),
         .src_in   (src_in[i]),
         .src_wr   (src_wr[i]),
         .cnt_wr   (cnt_wr[i]),
         .wdata    (reg_wdata[W-1:0]),
         .src      (src[i]),
         .cnt      (cnt[i]),
         .wrap     (wrap[i])
      );
   end

   ////////////////////////////////////////////////////////////////////////////////
   // rollover flags and read data

   always_comb begin
      d = q;
      for (int i = 0; i < 3; i++) begin
         // set beats a same-cycle write-one clear
         if (wrap[i]) begin
            d.roll[i] = 1'b1;
         end else if (stat_wr && reg_wdata[`ROLL_LSB+i]) begin
            d.roll[i] = 1'b0;
         end
      end
      if (reg_rd) begin
         if (sel(reg_addr, `MISC_SRC_OFS)) begin
            d.rdata = src[CLASS_MISC];
         end else if (sel(reg_addr, `MISC_CNT_OFS)) begin
            d.rdata = cnt[CLASS_MISC];
         end else if (sel(reg_addr, `UNDER_SRC_OFS)) begin
            d.rdata = src[CLASS_UNDER];
         end else if (sel(reg_addr, `UNDER_CNT_OFS)) begin
            d.rdata = cnt[CLASS_UNDER];
         end else if (sel(reg_addr, `OVER_SRC_OFS)) begin
            d.rdata = src[CLASS_OVER];
         end else if (sel(reg_addr, `OVER_CNT_OFS)) begin
            d.rdata = cnt[CLASS_OVER];
         end else begin
            d.rdata = `EVT_RESET;
         end
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         q.rdata <= `EVT_RESET;
         q.roll  <= `ROLL_RESET;
      end else begin
         q <= d;
      end
   end

   assign reg_rdata              = q.rdata;
   assign misc_rollover_flag     = q.roll[CLASS_MISC];
   assign underrun_rollover_flag = q.roll[CLASS_UNDER];
   assign overrun_rollover_flag  = q.roll[CLASS_OVER];

   ////////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);

   misc_src_load_a: assert property (
      hit[CLASS_MISC] && !src_wr[CLASS_MISC]
      |=> src[CLASS_MISC] == $past(misc_struct_addr))
   else $error("misc source not loaded on event");

   misc_unsel_hold_a: assert property (
      !test_force_bit && !(|(misc_error_set & misc_select)) && !src_wr[CLASS_MISC]
      && !cnt_wr[CLASS_MISC]
      |=> $stable(src[CLASS_MISC]) && $stable(cnt[CLASS_MISC]))
   else $error("misc registers changed on unselected error");

   misc_count_a: assert property (
      (|(misc_error_set & misc_select)) && !cnt_wr[CLASS_MISC]
      |=> cnt[CLASS_MISC] == W'($past(cnt[CLASS_MISC]) + 1'b1))
   else $error("misc counter missed a selected error");

   test_force_a: assert property (
      test_force_bit && !reg_wr
      |=> cnt[CLASS_MISC] == W'($past(cnt[CLASS_MISC]) + 1'b1)
      && cnt[CLASS_UNDER] == W'($past(cnt[CLASS_UNDER]) + 1'b1)
      && cnt[CLASS_OVER] == W'($past(cnt[CLASS_OVER]) + 1'b1))
   else $error("test force did not bump every counter");

   force_run_a: assert property (
      (test_force_bit && !reg_wr) [*3]
      |-> cnt[CLASS_UNDER] == W'($past(cnt[CLASS_UNDER], 2) + 2'd2))
   else $error("held test force did not count every cycle");

   under_src_a: assert property (
      hit[CLASS_UNDER] && !src_wr[CLASS_UNDER]
      |=> src[CLASS_UNDER] == $past(underrun_struct_addr))
   else $error("underrun source not loaded");

   under_cnt_a: assert property (
      !cnt_wr[CLASS_UNDER]
      |=> cnt[CLASS_UNDER] == W'($past(cnt[CLASS_UNDER])
          + W'($past(underrun_event | test_force_bit))))
   else $error("underrun count step wrong");

   over_src_a: assert property (
      hit[CLASS_OVER] && !src_wr[CLASS_OVER]
      |=> src[CLASS_OVER] == $past(overrun_struct_addr))
   else $error("overrun source not loaded");

   over_cnt_a: assert property (
      !cnt_wr[CLASS_OVER]
      |=> cnt[CLASS_OVER] == W'($past(cnt[CLASS_OVER])
          + W'($past(overrun_event | test_force_bit))))
   else $error("overrun count step wrong");

   roll_set_a: assert property (
      hit[CLASS_MISC] && !cnt_wr[CLASS_MISC] && cnt[CLASS_MISC] == '1
      |=> misc_rollover_flag && cnt[CLASS_MISC] == '0)
   else $error("misc rollover not flagged");

   roll_clear_a: assert property (
      stat_wr && reg_wdata[`ROLL_LSB+1] && !wrap[CLASS_UNDER]
      |=> !underrun_rollover_flag)
   else $error("underrun rollover flag not cleared");

   roll_hold_a: assert property (
      overrun_rollover_flag && !(stat_wr && reg_wdata[`ROLL_LSB+2])
      |=> overrun_rollover_flag)
   else $error("overrun rollover flag lost");

   sw_write_a: assert property (
      cnt_wr[CLASS_OVER]
      |=> cnt[CLASS_OVER] == $past(reg_wdata))
   else $error("counter write not stored");

   read_back_a: assert property (
      reg_rd && sel(reg_addr, `UNDER_SRC_OFS)
      |=> reg_rdata == $past(src[CLASS_UNDER]))
   else $error("read data does not match register");

   under_roll_set_a: assert property (
      hit[CLASS_UNDER] && !cnt_wr[CLASS_UNDER] && cnt[CLASS_UNDER] == '1
      |=> underrun_rollover_flag && cnt[CLASS_UNDER] == '0)
   else $error("underrun rollover not flagged");

   over_roll_set_a: assert property (
      hit[CLASS_OVER] && !cnt_wr[CLASS_OVER] && cnt[CLASS_OVER] == '1
      |=> overrun_rollover_flag && cnt[CLASS_OVER] == '0)
   else $error("overrun rollover not flagged");

   misc_roll_clear_a: assert property (
      stat_wr && reg_wdata[`ROLL_LSB] && !wrap[CLASS_MISC]
      |=> !misc_rollover_flag)
   else $error("misc rollover flag not cleared");

   over_roll_clear_a: assert property (
      stat_wr && reg_wdata[`ROLL_LSB+2] && !wrap[CLASS_OVER]
      |=> !overrun_rollover_flag)
   else $error("overrun rollover flag not cleared");

   misc_roll_hold_a: assert property (
      misc_rollover_flag && !(stat_wr && reg_wdata[`ROLL_LSB])
      |=> misc_rollover_flag)
   else $error("misc rollover flag lost");

   under_roll_hold_a: assert property (
      underrun_rollover_flag && !(stat_wr && reg_wdata[`ROLL_LSB+1])
      |=> underrun_rollover_flag)
   else $error("underrun rollover flag lost");

   set_beats_clear_a: assert property (
      wrap[CLASS_UNDER] && stat_wr && reg_wdata[`ROLL_LSB+1]
      |=> underrun_rollover_flag)
   else $error("same-cycle clear beat the rollover set");

   misc_src_write_a: assert property (
      src_wr[CLASS_MISC]
      |=> src[CLASS_MISC] == $past(reg_wdata))
   else $error("misc source write not stored");

   under_src_write_a: assert property (
      src_wr[CLASS_UNDER]
      |=> src[CLASS_UNDER] == $past(reg_wdata))
   else $error("underrun source write not stored");

   over_src_write_a: assert property (
      src_wr[CLASS_OVER]
      |=> src[CLASS_OVER] == $past(reg_wdata))
   else $error("overrun source write not stored");

   misc_cnt_write_a: assert property (
      cnt_wr[CLASS_MISC]
      |=> cnt[CLASS_MISC] == $past(reg_wdata))
   else $error("misc counter write not stored");

   under_cnt_write_a: assert property (
      cnt_wr[CLASS_UNDER]
      |=> cnt[CLASS_UNDER] == $past(reg_wdata))
   else $error("underrun counter write not stored");

   read_misc_cnt_a: assert property (
      reg_rd && sel(reg_addr, `MISC_CNT_OFS)
      |=> reg_rdata == $past(cnt[CLASS_MISC]))
   else $error("misc count read data wrong");

   read_over_src_a: assert property (
      reg_rd && sel(reg_addr, `OVER_SRC_OFS)
      |=> reg_rdata == $past(src[CLASS_OVER]))
   else $error("overrun source read data wrong");

   rdata_hold_a: assert property (
      !reg_rd
      |=> $stable(reg_rdata))
   else $error("read data changed without a read");

   misc_event_c: cover property (misc_real && !test_force_bit);
   write_clash_c: cover property (cnt_wr[CLASS_UNDER] && hit[CLASS_UNDER]);
   force_c:      cover property (test_force_bit [*3]);
   rollover_c:   cover property (wrap[CLASS_UNDER] ##1 stat_wr);
   clash_c:      cover property (wrap[CLASS_MISC] && stat_wr && reg_wdata[`ROLL_LSB]);

endmodule : receive_reassembly_engine_event_logger

// *** testbench/receive_reassembly_engine_event_logger_test.sv ***
`timescale 1ns/10ps
`include "receive_reassembly_engine_event_defs.svh"
module receive_reassembly_engine_event_logger_test;
   import receive_reassembly_engine_event_pkg::*;

   logic        core_clk;
   logic        sys_rst;
   logic [15:0] reg_addr;
   logic        reg_wr;
   logic        reg_rd;
   logic [15:0] reg_wdata;
   logic [15:0] reg_rdata;
   logic [4:0]  misc_select;
   logic        test_force_bit;
   logic [4:0]  misc_error_set;
   logic [15:0] misc_struct_addr;
   logic        underrun_event;
   logic [15:0] underrun_struct_addr;
   logic        overrun_event;
   logic [15:0] overrun_struct_addr;
   logic [2:0]  flags;
   int          n_mismatch;
   int          checked;
   int          cycles;
   logic [15:0] src_ofs [3] = '{`MISC_SRC_OFS, `UNDER_SRC_OFS, `OVER_SRC_OFS};
   logic [15:0] cnt_ofs [3] = '{`MISC_CNT_OFS, `UNDER_CNT_OFS, `OVER_CNT_OFS};

   receive_reassembly_engine_event_logger u_receive_reassembly_engine_event_logger (
      .core_clk               (core_clk),
      .sys_rst                (sys_rst),
      .reg_addr               (reg_addr),
      .reg_wr                 (reg_wr),
      .reg_rd                 (reg_rd),
      .reg_wdata              (reg_wdata),
      .reg_rdata              (reg_rdata),
      .misc_select            (misc_select),
      .test_force_bit         (test_force_bit),
      .misc_error_set         (misc_error_set),
      .misc_struct_addr       (misc_struct_addr),
      .underrun_event         (underrun_event),
      .underrun_struct_addr   (underrun_struct_addr),
      .overrun_event          (overrun_event),
      .overrun_struct_addr    (overrun_struct_addr),
      .misc_rollover_flag     (flags[0]),
      .underrun_rollover_flag (flags[1]),
      .overrun_rollover_flag  (flags[2])
   );

   ////////////////////////////////////////////////////////////////////////
   task automatic close_out;
      $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : close_out

   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   task automatic chk_flag(input string n, input logic e, input logic g);
      checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("[ERR] %s expected %b seen %b", n, e, g);
      end
   endtask : chk_flag

   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(negedge core_clk);
      reg_addr  = a;
      reg_wdata = d;
      reg_wr    = 1'b1;
      @(negedge core_clk);
      reg_wr = 1'b0;
   endtask : wr

   task automatic rd(input string n, input logic [15:0] a, input logic [15:0] e);
      @(negedge core_clk);
      reg_addr = a;
      reg_rd   = 1'b1;
      @(negedge core_clk);
      reg_rd = 1'b0;
      chk(n, e, reg_rdata);
   endtask : rd

   // events held for n cycles, then dropped
   task automatic ev(input logic [4:0] m, input logic u, input logic o, input logic tf,
                     input int n);
      @(negedge core_clk);
      misc_error_set = m;
      underrun_event = u;
      overrun_event  = o;
      test_force_bit = tf;
      repeat (n) @(negedge core_clk);
      {misc_error_set, underrun_event, overrun_event, test_force_bit} = '0;
   endtask : ev

   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      for (int i = 0; i < 3; i++) begin
         rd("src reset", src_ofs[i], `EVT_RESET);
         rd("cnt reset", cnt_ofs[i], `EVT_RESET);
      end
      chk("flags reset", {13'h0, `ROLL_RESET}, {13'h0, flags});
   endtask : t_reset

   task automatic t_rw;
      for (int i = 0; i < 3; i++) begin
         wr(src_ofs[i], 16'hA50F ^ 16'(i));
         wr(cnt_ofs[i], 16'h5AF0 ^ 16'(i));
      end
      wr(16'h3014, 16'hFFFF);
      rd("unmapped", 16'h3014, 16'h0000);
      for (int i = 0; i < 3; i++) begin
         rd("src rw", src_ofs[i], 16'hA50F ^ 16'(i));
         rd("cnt rw", cnt_ofs[i], 16'h5AF0 ^ 16'(i));
      end
   endtask : t_rw

   task automatic t_misc;
      misc_select      = 5'b00101;
      misc_struct_addr = 16'hC3A5;
      wr(`MISC_CNT_OFS, 16'h0000);
      ev(5'b11010, 1'b0, 1'b0, 1'b0, 1);
      rd("misc src unsel", `MISC_SRC_OFS, 16'hA50F);
      rd("misc cnt unsel", `MISC_CNT_OFS, 16'h0000);
      ev(5'b00101, 1'b0, 1'b0, 1'b0, 1);
      rd("misc src", `MISC_SRC_OFS, 16'hC3A5);
      rd("misc cnt", `MISC_CNT_OFS, 16'h0001);
      misc_struct_addr = 16'h1234;
      ev(5'b00100, 1'b0, 1'b0, 1'b0, 2);
      rd("misc src 2", `MISC_SRC_OFS, 16'h1234);
      rd("misc cnt 2", `MISC_CNT_OFS, 16'h0003);
   endtask : t_misc

   task automatic t_under_over;
      underrun_struct_addr = 16'h0F1E;
      overrun_struct_addr  = 16'hE1F0;
      ev(5'b00000, 1'b1, 1'b0, 1'b0, 1);
      ev(5'b00000, 1'b1, 1'b1, 1'b0, 1);
      rd("under src", `UNDER_SRC_OFS, 16'h0F1E);
      rd("under cnt", `UNDER_CNT_OFS, 16'h5AF3);
      rd("over src", `OVER_SRC_OFS, 16'hE1F0);
      rd("over cnt", `OVER_CNT_OFS, 16'h5AF3);
   endtask : t_under_over

   task automatic t_force;
      misc_select          = 5'b00000;
      misc_struct_addr     = 16'h7001;
      underrun_struct_addr = 16'h7002;
      overrun_struct_addr  = 16'h7003;
      for (int i = 0; i < 3; i++) wr(cnt_ofs[i], 16'h0000);
      ev(5'b00000, 1'b0, 1'b0, 1'b1, 3);
      for (int i = 0; i < 3; i++) begin
         rd("forced src", src_ofs[i], 16'h7001 + 16'(i));
         rd("forced cnt", cnt_ofs[i], 16'h0003);
      end
   endtask : t_force

   task automatic t_roll;
      misc_select = 5'b00001;
      for (int i = 0; i < 3; i++) begin
         wr(cnt_ofs[i], 16'hFFFF);
         ev((i == 0) ? 5'b00001 : 5'b00000, i == 1, i == 2, 1'b0, 1);
         rd("wrapped cnt", cnt_ofs[i], 16'h0000);
         chk_flag("roll set", 1'b1, flags[i]);
         wr(`STATUS_OFS, 16'h0001 << (`ROLL_LSB + i));
         chk_flag("roll clear", 1'b0, flags[i]);
      end
   endtask : t_roll

   task automatic t_clash;
      wr(`UNDER_CNT_OFS, 16'hFFFF);
      @(negedge core_clk);
      reg_addr       = `STATUS_OFS;
      reg_wdata      = 16'h2000;
      reg_wr         = 1'b1;
      underrun_event = 1'b1;
      @(negedge core_clk);
      reg_wr         = 1'b0;
      underrun_event = 1'b0;
      chk_flag("set beats clear", 1'b1, flags[1]);
      rd("clash wrap", `UNDER_CNT_OFS, 16'h0000);
      @(negedge core_clk);
      reg_addr       = `UNDER_CNT_OFS;
      reg_wdata      = 16'h0042;
      reg_wr         = 1'b1;
      underrun_event = 1'b1;
      @(negedge core_clk);
      reg_wr         = 1'b0;
      underrun_event = 1'b0;
      rd("write beats event", `UNDER_CNT_OFS, 16'h0042);
   endtask : t_clash

   ////////////////////////////////////////////////////////////////////////
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end

   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 5000) begin
         n_mismatch++;
         close_out();
      end
   end

   initial begin
      {reg_addr, reg_wr, reg_rd, reg_wdata, misc_select, test_force_bit} = '0;
      {misc_error_set, misc_struct_addr, underrun_event, underrun_struct_addr} = '0;
      {overrun_event, overrun_struct_addr} = '0;
      n_mismatch = 0;
      checked    = 0;
      cycles     = 0;
      sys_rst    = 1'b1;
      repeat (12) @(negedge core_clk);
      sys_rst = 1'b0;
      t_reset();
      t_rw();
      t_misc();
      t_under_over();
      t_force();
      t_roll();
      t_clash();
      close_out();
   end

endmodule : receive_reassembly_engine_event_logger_test
